/* hw/mds_core.sv */
`timescale 1ns/1ns
// Contract
// (RL1) Enabled time base irq branches to 014H, real time clock to 018H, if room.
// (RL2) Current page table address is program counter bits 11..8 then table_pointer.
// (RL3) Last page table address forces bits 11..8 high, low byte from table_pointer.
// (RL4) Table low byte goes to memory; upper seven bits to table_high_byte, top zero.
// (RL5) table_high_byte is read only; table_pointer at 07H reads and writes.
// (RL6) Every table read takes two instruction cycles.
// (RL7) Six-entry return stack, invisible to software, index included.
// (RL8) Call or irq acknowledge pushes program counter; both exits pop it.
// (RL9) Reset leaves the stack empty.
// (RL10) Full stack withholds irq acknowledge until a return frees an entry.
// (RL11) Call on full stack drops the oldest entry, keeping six newest.
// (RL12) Special registers sit at their fixed data addresses 00H to 1EH.
// (RL13) General data memory spans 60H to FFH.
// (RL14) Bits set and clear singly; memory also reachable through both pointers.
// (RL15) Ports 00H and 02H access the location named by pointer 0 or 1.
// (RL16) Pointer naming 00H or 02H reads zero and ignores writes.
// (RL17) Pointers are 8 bits; pointer 1 may reach display memory.
// (RL18) work_register sits at 05H, takes immediates, carries memory copies.
// (RL19) ALU does add, subtract, decimal adjust, logic, rotates, inc, dec, skips.
// (RL20) Status writes change arithmetic flags but never timeout or power down bits.
// (RL21) Timeout and power down change only by watchdog, power-up, clear, halt.
// (RL22) Calls and irq entry never save the status register.
// (RL23) Status bits: carry, aux, zero, wrap, power down, timeout; 6..7 zero.
// (RL24) Wrap flag is carry into bit 7 differing from carry out.
module mds_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic opValid,
    input wire mds_pkg::mds_op_t opCode,
    input wire logic [7:0] opAddr,
    input wire logic [7:0] opImm,
    input wire logic opImmSel,
    input wire logic opToWork,
    input wire logic [2:0] opBit,
    input wire logic [11:0] callAddr,
    input wire logic [11:0] progCnt,
    input wire logic [14:0] romData,
    input wire logic [7:0] extRdData,
    input wire logic wdtOverflow,
    input wire logic tbIrqReq,
    input wire logic rtcIrqReq,
    output logic busy,
    output logic romRead,
    output logic [11:0] romAddr,
    output logic pcLoad,
    output logic [11:0] pcTarget,
    output logic skip,
    output logic extWr,
    output logic extLcd,
    output logic [7:0] extAddr,
    output logic [7:0] extData,
    output logic tbAck,
    output logic rtcAck,
    output logic stackFull,
    output logic [7:0] workOut
);
    import mds_pkg::*;
    typedef enum logic {ST_RUN, ST_TAB} mds_st_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Bit 8 is the valid flag: a pointer that names a port itself reaches nothing.
    function automatic logic [8:0] resolveAddr(input logic [7:0] a, input logic [7:0] p0,
                                               input logic [7:0] p1);
        logic [7:0] t;
        logic ind;
        ind = (a == ADDR_IND0) || (a == ADDR_IND1);
        t = (a == ADDR_IND0) ? p0 : ((a == ADDR_IND1) ? p1 : a);
        resolveAddr = {!(ind && (t == ADDR_IND0 || t == ADDR_IND1)), t};
    endfunction

    function automatic logic isExt(input logic [7:0] a);
        isExt = a == ADDR_RTCCTL || a == ADDR_IRQC0 || a == ADDR_TM0CNT ||
                a == ADDR_TM0CTL || a == ADDR_TM1CNT || a == ADDR_TM1CTL ||
                a == ADDR_PORTA || a == ADDR_PORTB || a == ADDR_PORTC || a == ADDR_IRQC1;
    endfunction

    mds_st_t st_r, st_nxt;
    logic [7:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt, bank_r, bank_nxt, work_r, work_nxt;
    logic [7:0] tptr_r, tptr_nxt, tabDest_r, tabDest_nxt;
    logic [6:0] thigh_r, thigh_nxt;
    logic carry_r, carry_nxt, aux_r, aux_nxt, zero_r, zero_nxt, wrap_r, wrap_nxt;
    logic pdown_r, pdown_nxt, wdto_r, wdto_nxt;
    logic busy_r, busy_nxt, romRead_r, romRead_nxt, pcLoad_r, pcLoad_nxt, skip_r, skip_nxt;
    logic [11:0] romAddr_r, romAddr_nxt, pcTarget_r, pcTarget_nxt;
    logic extWr_r, extWr_nxt, extLcd_r, extLcd_nxt, tbAck_r, tbAck_nxt, rtcAck_r, rtcAck_nxt;
    logic [7:0] extAddr_r, extAddr_nxt, extData_r, extData_nxt;
    logic [2:0] top_r, top_nxt, used_r, used_nxt;
    logic full_r, full_nxt;
    logic [7:0] ram [RAM_WORDS];
    logic [11:0] stk [6];
    logic [8:0] ea, sum, dadj;
    logic [4:0] nib;
    logic [7:0] src, rd, opB, bx, res, statB, ramIdx;
    logic [2:0] popIdx;
    logic cin, wrEn, toW, updC, updA, updZ, updV, newC, lcdSel, push, pop, ramWe;
    logic [11:0] pushVal;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        ptr0_nxt = ptr0_r;
        ptr1_nxt = ptr1_r;
        bank_nxt = bank_r;
        work_nxt = work_r;
        tptr_nxt = tptr_r;
        tabDest_nxt = tabDest_r;
        thigh_nxt = thigh_r;
        carry_nxt = carry_r;
        aux_nxt = aux_r;
        zero_nxt = zero_r;
        wrap_nxt = wrap_r;
        pdown_nxt = pdown_r;
        wdto_nxt = wdto_r;
        busy_nxt = busy_r;
        romRead_nxt = 1'b0;
        romAddr_nxt = romAddr_r;
        pcLoad_nxt = 1'b0;
        pcTarget_nxt = pcTarget_r;
        skip_nxt = 1'b0;
        extWr_nxt = 1'b0;
        extLcd_nxt = 1'b0;
        extAddr_nxt = extAddr_r;
        extData_nxt = extData_r;
        tbAck_nxt = 1'b0;
        rtcAck_nxt = 1'b0;
        top_nxt = top_r;
        used_nxt = used_r;
        push = 1'b0;
        pop = 1'b0;
        pushVal = progCnt;
        ramWe = 1'b0;
        wrEn = 1'b0;
        toW = opToWork;
        updC = 1'b0;
        updA = 1'b0;
        updZ = 1'b0;
        updV = 1'b0;
        src = (st_r == ST_TAB) ? tabDest_r : opAddr;
        ea = resolveAddr(src, ptr0_r, ptr1_r); // RL15 RL16
        lcdSel = (src == ADDR_IND1) && (bank_r != RST_BYTE); // RL17
        ramIdx = ea[7:0] - ADDR_RAM_LO;
        statB = 8'h00; // RL23
        statB[BIT_CARRY] = carry_r;
        statB[BIT_AUX] = aux_r;
        statB[BIT_ZERO] = zero_r;
        statB[BIT_WRAP] = wrap_r;
        statB[BIT_PDOWN] = pdown_r;
        statB[BIT_WDTO] = wdto_r;
        rd = 8'h00;
        if (ea[8]) begin
            if (lcdSel || isExt(ea[7:0])) begin
                rd = extRdData;
            end else if (ea[7:0] >= ADDR_RAM_LO) begin
                rd = ram[ramIdx]; // RL13
            end else begin
                case (ea[7:0]) // RL12
                    ADDR_PTR0: rd = ptr0_r;
                    ADDR_PTR1: rd = ptr1_r;
                    ADDR_BANK: rd = bank_r;
                    ADDR_WORK: rd = work_r; // RL18
                    ADDR_PCLOW: rd = progCnt[7:0];
                    ADDR_TPTR: rd = tptr_r; // RL5
                    ADDR_THIGH: rd = {1'b0, thigh_r}; // RL4
                    ADDR_STATUS: rd = statB;
                    default: rd = 8'h00;
                endcase
            end
        end
        // Add, subtract and logic operations pair work_register with memory or an immediate.
        opB = opImmSel ? opImm : rd;
        bx = (opCode == OP_SUB || opCode == OP_SBC) ? ~opB : opB;
        cin = (opCode == OP_SUB) || ((opCode == OP_ADC || opCode == OP_SBC) && carry_r);
        nib = {1'b0, work_r[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
        sum = {1'b0, work_r} + {1'b0, bx} + {8'h00, cin};
        dadj = {1'b0, work_r} + ((work_r[3:0] > 4'h9 || aux_r) ? 9'h006 : 9'h000);
        if (carry_r || dadj[8] || dadj[7:4] > 4'h9) begin
            dadj = dadj + 9'h060;
        end
        res = rd;
        newC = carry_r;
        popIdx = (top_r == 3'h0) ? STACK_LAST : top_r - 3'h1;
        if (st_r == ST_TAB) begin
            res = romData[7:0]; // RL4
            thigh_nxt = romData[14:8];
            wrEn = 1'b1;
            toW = 1'b0;
            busy_nxt = 1'b0; // RL6
            st_nxt = ST_RUN;
        end else if (opValid) begin
            case (opCode) // RL19
                OP_LD_WORK: begin
                    wrEn = 1'b1;
                    toW = 1'b1;
                end
                OP_ST_WORK: begin
                    res = work_r; // RL18
                    wrEn = 1'b1;
                    toW = 1'b0;
                end
                OP_IMM_WORK: begin
                    res = opImm;
                    wrEn = 1'b1;
                    toW = 1'b1;
                end
                OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                    res = sum[7:0];
                    newC = sum[8];
                    wrEn = 1'b1;
                    {updC, updA, updZ, updV} = 4'hF;
                end
                OP_DAA: begin
                    res = dadj[7:0];
                    newC = dadj[8] | carry_r;
                    wrEn = 1'b1;
                    updC = 1'b1;
                end
                OP_AND, OP_OR, OP_XOR: begin
                    res = (opCode == OP_AND) ? (work_r & opB) :
                          ((opCode == OP_OR) ? (work_r | opB) : (work_r ^ opB));
                    wrEn = 1'b1;
                    updZ = 1'b1;
                end
                OP_CPL, OP_INC, OP_DEC: begin
                    res = (opCode == OP_CPL) ? ~rd : ((opCode == OP_INC) ? rd + 8'h01 : rd - 8'h01);
                    wrEn = 1'b1;
                    updZ = 1'b1;
                end
                OP_RL, OP_RR, OP_RLC, OP_RRC: begin
                    case (opCode)
                        OP_RL: res = {rd[6:0], rd[7]};
                        OP_RR: res = {rd[0], rd[7:1]};
                        OP_RLC: res = {rd[6:0], carry_r};
                        default: res = {carry_r, rd[7:1]};
                    endcase
                    newC = (opCode == OP_RLC) ? rd[7] : rd[0];
                    updC = (opCode == OP_RLC) || (opCode == OP_RRC);
                    wrEn = 1'b1;
                end
                OP_SZ, OP_SNZ: begin
                    skip_nxt = (rd == 8'h00) ^ (opCode == OP_SNZ);
                end
                OP_SIZ, OP_SDZ: begin
                    res = (opCode == OP_SIZ) ? rd + 8'h01 : rd - 8'h01;
                    skip_nxt = res == 8'h00;
                    wrEn = 1'b1;
                end
                OP_BSET, OP_BCLR: begin
                    res = rd;
                    res[opBit] = opCode == OP_BSET; // RL14
                    wrEn = 1'b1;
                    toW = 1'b0;
                end
                OP_CALL: begin
                    push = 1'b1; // RL8 RL22
                    pcLoad_nxt = 1'b1;
                    pcTarget_nxt = callAddr;
                end
                OP_SUB_EXIT, OP_IRQ_EXIT: begin
                    pop = 1'b1; // RL8
                    pcLoad_nxt = 1'b1;
                    pcTarget_nxt = stk[popIdx];
                end
                OP_TAB_CUR, OP_TAB_LAST: begin
                    romAddr_nxt = {(opCode == OP_TAB_CUR) ? progCnt[11:8] : LAST_PAGE,
                                   tptr_r}; // RL2 RL3
                    romRead_nxt = 1'b1;
                    busy_nxt = 1'b1; // RL6
                    tabDest_nxt = opAddr;
                    st_nxt = ST_TAB;
                end
                OP_WDT_CLR: begin
                    pdown_nxt = 1'b0; // RL21
                    wdto_nxt = 1'b0;
                end
                OP_HALT: begin
                    pdown_nxt = 1'b1; // RL21
                    wdto_nxt = 1'b0;
                end
                default: begin
                    res = rd;
                end
            endcase
        end else if (!full_r && (tbIrqReq || rtcIrqReq)) begin
            // A full stack holds requests off; they are served once an exit pops.
            push = 1'b1; // RL10 RL8
            pcLoad_nxt = 1'b1;
            tbAck_nxt = tbIrqReq;
            rtcAck_nxt = !tbIrqReq;
            pcTarget_nxt = tbIrqReq ? VEC_TIMEBASE : VEC_RTC; // RL1
        end
        if (wrEn && toW) begin
            work_nxt = res;
        end else if (wrEn && ea[8]) begin
            if (lcdSel || isExt(ea[7:0])) begin
                extWr_nxt = 1'b1;
                extLcd_nxt = lcdSel;
                extAddr_nxt = ea[7:0];
                extData_nxt = res;
            end else if (ea[7:0] >= ADDR_RAM_LO) begin
                ramWe = 1'b1; // RL13 RL14
            end else begin
                case (ea[7:0]) // RL12
                    ADDR_PTR0: ptr0_nxt = res; // RL17
                    ADDR_PTR1: ptr1_nxt = res;
                    ADDR_BANK: bank_nxt = res;
                    ADDR_WORK: work_nxt = res;
                    ADDR_TPTR: tptr_nxt = res; // RL5
                    ADDR_PCLOW: begin
                        pcLoad_nxt = 1'b1;
                        pcTarget_nxt = {progCnt[11:8], res};
                    end
                    ADDR_STATUS: begin
                        carry_nxt = res[BIT_CARRY]; // RL20
                        aux_nxt = res[BIT_AUX];
                        zero_nxt = res[BIT_ZERO];
                        wrap_nxt = res[BIT_WRAP];
                    end
                    default: begin
                        tptr_nxt = tptr_r;
                    end
                endcase
            end
        end
        // Flags from the operation itself win over a store into the status byte.
        if (updC) begin
            carry_nxt = newC;
        end
        if (updA) begin
            aux_nxt = nib[4];
        end
        if (updZ) begin
            zero_nxt = res == 8'h00;
        end
        if (updV) begin
            wrap_nxt = sum[8] ^ (work_r[7] ^ bx[7] ^ sum[7]); // RL24
        end
        if (wdtOverflow) begin
            wdto_nxt = 1'b1; // RL21
        end
        if (push) begin
            top_nxt = (top_r == STACK_LAST) ? 3'h0 : top_r + 3'h1; // RL11
            used_nxt = full_r ? used_r : used_r + 3'h1;
        end else if (pop && used_r != 3'h0) begin
            top_nxt = popIdx;
            used_nxt = used_r - 3'h1;
        end
        full_nxt = used_nxt == STACK_DEPTH;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_RUN;
            {ptr0_r, ptr1_r, bank_r, work_r} <= {4{RST_BYTE}};
            {tptr_r, tabDest_r, extAddr_r, extData_r} <= {4{RST_BYTE}};
            thigh_r <= 7'h00;
            {carry_r, aux_r, zero_r, wrap_r, pdown_r, wdto_r} <= 6'h00;
            {busy_r, romRead_r, pcLoad_r, skip_r, extWr_r, extLcd_r} <= 6'h00;
            {tbAck_r, rtcAck_r, full_r} <= 3'h0;
            romAddr_r <= 12'h000;
            pcTarget_r <= 12'h000;
            top_r <= 3'h0; // RL9
            used_r <= 3'h0;
        end else begin
            st_r <= st_nxt;
            {ptr0_r, ptr1_r, bank_r, work_r} <= {ptr0_nxt, ptr1_nxt, bank_nxt, work_nxt};
            {tptr_r, tabDest_r, extAddr_r, extData_r} <=
                {tptr_nxt, tabDest_nxt, extAddr_nxt, extData_nxt};
            thigh_r <= thigh_nxt;
            {carry_r, aux_r, zero_r, wrap_r, pdown_r, wdto_r} <=
                {carry_nxt, aux_nxt, zero_nxt, wrap_nxt, pdown_nxt, wdto_nxt};
            {busy_r, romRead_r, pcLoad_r, skip_r, extWr_r, extLcd_r} <=
                {busy_nxt, romRead_nxt, pcLoad_nxt, skip_nxt, extWr_nxt, extLcd_nxt};
            {tbAck_r, rtcAck_r, full_r} <= {tbAck_nxt, rtcAck_nxt, full_nxt};
            romAddr_r <= romAddr_nxt;
            pcTarget_r <= pcTarget_nxt;
            top_r <= top_nxt;
            used_r <= used_nxt;
        end
    end

    // Storage arrays carry no reset; the stack is kept out of data space entirely.
    always_ff @(posedge clk) begin
        if (ramWe) begin
            ram[ramIdx] <= res;
        end
        if (push) begin
            stk[top_r] <= pushVal; // RL7 RL11
        end
    end

    assign busy = busy_r;
    assign romRead = romRead_r;
    assign romAddr = romAddr_r;
    assign pcLoad = pcLoad_r;
    assign pcTarget = pcTarget_r;
    assign skip = skip_r;
    assign extWr = extWr_r;
    assign extLcd = extLcd_r;
    assign extAddr = extAddr_r;
    assign extData = extData_r;
    assign tbAck = tbAck_r;
    assign rtcAck = rtcAck_r;
    assign stackFull = full_r;
    assign workOut = work_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_vector;
        @(posedge clk) disable iff (rst)
        (tbAck_r || rtcAck_r) |-> pcLoad_r && pcTarget_r == (tbAck_r ? VEC_TIMEBASE : VEC_RTC);
    endproperty
    a_vector: assert property (p_vector) else $error("bad irq vector"); // RL1
    property p_tabCur;
        @(posedge clk) disable iff (rst)
        opValid && opCode == OP_TAB_CUR && st_r == ST_RUN
        |=> romAddr_r == {$past(progCnt[11:8]), $past(tptr_r)};
    endproperty
    a_tabCur: assert property (p_tabCur) else $error("bad current page address"); // RL2
    property p_tabLast;
        @(posedge clk) disable iff (rst)
        opValid && opCode == OP_TAB_LAST && st_r == ST_RUN
        |=> romRead_r && romAddr_r[11:8] == LAST_PAGE && romAddr_r[7:0] == $past(tptr_r);
    endproperty
    a_tabLast: assert property (p_tabLast) else $error("bad last page address"); // RL3
    property p_tabHigh;
        @(posedge clk) disable iff (rst)
        st_r == ST_TAB |=> thigh_r == $past(romData[14:8]);
    endproperty
    a_tabHigh: assert property (p_tabHigh) else $error("high byte not captured"); // RL4
    property p_tabLen;
        @(posedge clk) disable iff (rst)
        $rose(busy_r) |-> busy_r ##1 !busy_r;
    endproperty
    a_tabLen: assert property (p_tabLen) else $error("table read not two cycles"); // RL6
    property p_fullHold;
        @(posedge clk) disable iff (rst)
        full_r |-> !tbAck_nxt && !rtcAck_nxt;
    endproperty
    a_fullHold: assert property (p_fullHold) else $error("irq taken on full stack"); // RL10
    property p_overCall;
        @(posedge clk) disable iff (rst)
        full_r && st_r == ST_RUN && opValid && opCode == OP_CALL |=> full_r && used_r == 3'h6;
    endproperty
    a_overCall: assert property (p_overCall) else $error("overflow call lost depth"); // RL11
    property p_nullPtr;
        @(posedge clk) disable iff (rst)
        st_r == ST_RUN && opValid && opCode == OP_LD_WORK && opAddr == ADDR_IND0 &&
        (ptr0_r == ADDR_IND0 || ptr0_r == ADDR_IND1) |=> work_r == 8'h00;
    endproperty
    a_nullPtr: assert property (p_nullPtr) else $error("null pointer read not zero"); // RL16
    property p_statKeep;
        @(posedge clk) disable iff (rst)
        st_r == ST_RUN && opValid && opCode == OP_ST_WORK && opAddr == ADDR_STATUS &&
        !wdtOverflow |=> $stable(pdown_r) && $stable(wdto_r);
    endproperty
    a_statKeep: assert property (p_statKeep) else $error("status write moved wdt bits"); // RL20
endmodule

/* hw/mds_pkg.sv */
package mds_pkg;
    // ----------------------------------------
    // Data space map
    // ----------------------------------------
    localparam logic [7:0] ADDR_IND0 = 8'h00;
    localparam logic [7:0] ADDR_PTR0 = 8'h01;
    localparam logic [7:0] ADDR_IND1 = 8'h02;
    localparam logic [7:0] ADDR_PTR1 = 8'h03;
    localparam logic [7:0] ADDR_BANK = 8'h04;
    localparam logic [7:0] ADDR_WORK = 8'h05;
    localparam logic [7:0] ADDR_PCLOW = 8'h06;
    localparam logic [7:0] ADDR_TPTR = 8'h07;
    localparam logic [7:0] ADDR_THIGH = 8'h08;
    localparam logic [7:0] ADDR_RTCCTL = 8'h09;
    localparam logic [7:0] ADDR_STATUS = 8'h0A;
    localparam logic [7:0] ADDR_IRQC0 = 8'h0B;
    localparam logic [7:0] ADDR_TM0CNT = 8'h0D;
    localparam logic [7:0] ADDR_TM0CTL = 8'h0E;
    localparam logic [7:0] ADDR_TM1CNT = 8'h10;
    localparam logic [7:0] ADDR_TM1CTL = 8'h11;
    localparam logic [7:0] ADDR_PORTA = 8'h12;
    localparam logic [7:0] ADDR_PORTB = 8'h14;
    localparam logic [7:0] ADDR_PORTC = 8'h16;
    localparam logic [7:0] ADDR_IRQC1 = 8'h1E;
    localparam logic [7:0] ADDR_RAM_LO = 8'h60;
    localparam int RAM_WORDS = 160;
    // ----------------------------------------
    // Status bits, vectors, stack, timing
    // ----------------------------------------
    localparam int BIT_CARRY = 0;
    localparam int BIT_AUX = 1;
    localparam int BIT_ZERO = 2;
    localparam int BIT_WRAP = 3;
    localparam int BIT_PDOWN = 4;
    localparam int BIT_WDTO = 5;
    localparam logic [11:0] VEC_TIMEBASE = 12'h014;
    localparam logic [11:0] VEC_RTC = 12'h018;
    localparam logic [3:0] LAST_PAGE = 4'hF;
    localparam logic [2:0] STACK_DEPTH = 3'h6;
    localparam logic [2:0] STACK_LAST = 3'h5;
    localparam int TABLE_CYCLES = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    typedef enum logic [4:0] {
        OP_NOP, OP_LD_WORK, OP_ST_WORK, OP_IMM_WORK, OP_ADD, OP_ADC, OP_SUB, OP_SBC,
        OP_DAA, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_RL, OP_RR, OP_RLC, OP_RRC, OP_INC,
        OP_DEC, OP_SZ, OP_SNZ, OP_SIZ, OP_SDZ, OP_BSET, OP_BCLR, OP_CALL, OP_SUB_EXIT,
        OP_IRQ_EXIT, OP_TAB_CUR, OP_TAB_LAST, OP_WDT_CLR, OP_HALT
    } mds_op_t;
endpackage

/* sim/mcu_data_memory_stack_table_read_tb.sv */
`timescale 1ns/1ns
module mcu_data_memory_stack_table_read_tb;
    import mds_pkg::*;
    logic clk, rst, opValid, opImmSel, opToWork, wdtOverflow, tbIrqReq, rtcIrqReq;
    mds_op_t opCode;
    logic [7:0] opAddr, opImm, extRdData, extAddr, extData, workOut;
    logic [2:0] opBit;
    logic [11:0] callAddr, progCnt, romAddr, pcTarget;
    logic [14:0] romData;
    logic busy, romRead, pcLoad, skip, extWr, extLcd, tbAck, rtcAck, stackFull;
    int nErrors = 0;
    int nTests = 0;
    mds_core mds_core_inst (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode),
        .opAddr(opAddr), .opImm(opImm), .opImmSel(opImmSel), .opToWork(opToWork),
        .opBit(opBit), .callAddr(callAddr), .progCnt(progCnt), .romData(romData),
        .extRdData(extRdData), .wdtOverflow(wdtOverflow), .tbIrqReq(tbIrqReq),
        .rtcIrqReq(rtcIrqReq), .busy(busy), .romRead(romRead), .romAddr(romAddr),
        .pcLoad(pcLoad), .pcTarget(pcTarget), .skip(skip), .extWr(extWr),
        .extLcd(extLcd), .extAddr(extAddr), .extData(extData), .tbAck(tbAck),
        .rtcAck(rtcAck), .stackFull(stackFull), .workOut(workOut));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        nTests++;
        if (g !== e) begin
            nErrors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Pulses are looked at 1 ns after the taking edge, once they have landed.
    task op(input mds_op_t c, input logic [7:0] a, input logic [7:0] im, input logic ws);
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= c;
        opAddr <= a;
        opImm <= im;
        opImmSel <= ws;
        opToWork <= ws;
        @(posedge clk);
        opValid <= 1'b0;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        op(OP_IMM_WORK, 8'h00, v, 1'b1);
        op(OP_ST_WORK, a, 8'h00, 1'b0);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        op(OP_LD_WORK, a, 8'h00, 1'b0);
        chk("readback", {8'h00, e}, {8'h00, workOut});
    endtask
    task ex(input logic [11:0] pop, input logic [11:0] vec);
        op(OP_SUB_EXIT, 8'h00, 8'h00, 1'b0);
        chk("pop", {4'h0, pop}, {4'h0, pcTarget});
        @(posedge clk);
        #1;
        chk("vector", {4'h0, vec}, {4'h0, pcTarget});
        chk("ack", {14'h0000, vec == VEC_TIMEBASE, vec == VEC_RTC}, {14'h0000, tbAck, rtcAck});
    endtask
    task wrap_up;
        if (nErrors == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // A hang would otherwise run forever; the sequence needs well under 1000 cycles.
    initial begin
        #20000;
        nErrors++;
        wrap_up;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {rst, opValid, opImmSel, opToWork, wdtOverflow, tbIrqReq, rtcIrqReq} = 7'h40;
        opCode = OP_NOP;
        {opAddr, opImm, opBit, callAddr} = '0;
        {progCnt, romData, extRdData} = {12'h7C5, 15'h5ABC, 8'h00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("stackFull", 16'h0000, {15'h0000, stackFull});
        op(OP_IMM_WORK, 8'h00, 8'h7F, 1'b1);
        op(OP_ADD, 8'h00, 8'h01, 1'b1);
        chk("sum", 16'h0080, {8'h00, workOut});
        rd(ADDR_STATUS, 8'h0A);
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, 8'h0F);
        @(posedge clk);
        wdtOverflow <= 1'b1;
        @(posedge clk);
        wdtOverflow <= 1'b0;
        rd(ADDR_STATUS, 8'h2F);
        op(OP_WDT_CLR, 8'h00, 8'h00, 1'b0);
        rd(ADDR_STATUS, 8'h0F);
        op(OP_IMM_WORK, 8'h00, 8'h07, 1'b1);
        op(OP_SUB, 8'h00, 8'h05, 1'b1);
        chk("diff", 16'h0002, {8'h00, workOut});
        rd(ADDR_STATUS, 8'h03);
        op(OP_SNZ, ADDR_WORK, 8'h00, 1'b0);
        chk("skip", 16'h0001, {15'h0000, skip});
        wr(ADDR_TPTR, 8'h34);
        rd(ADDR_TPTR, 8'h34);
        op(OP_TAB_LAST, 8'h60, 8'h00, 1'b0);
        chk("tabLast", 16'hCF34, {busy, romRead, 2'b00, romAddr});
        @(posedge clk);
        #1;
        chk("busyEnd", 16'h0000, {15'h0000, busy});
        op(OP_TAB_CUR, 8'h61, 8'h00, 1'b0);
        chk("tabCur", 16'hC734, {busy, romRead, 2'b00, romAddr});
        rd(8'h60, 8'hBC);
        wr(ADDR_THIGH, 8'hFF);
        rd(ADDR_THIGH, 8'h5A);
        wr(ADDR_PTR1, 8'h61);
        rd(ADDR_IND1, 8'hBC);
        wr(ADDR_PTR0, 8'h60);
        wr(ADDR_IND0, 8'h3C);
        rd(8'h60, 8'h3C);
        op(OP_BSET, 8'h60, 8'h00, 1'b0);
        rd(8'h60, 8'h3D);
        wr(ADDR_PTR0, ADDR_IND1);
        rd(ADDR_IND0, 8'h00);
        wr(ADDR_IRQC0, 8'h81);
        chk("extData", 16'h0B81, {extAddr, extData});
        chk("extWr", 16'h0002, {14'h0000, extWr, extLcd});
        wr(ADDR_BANK, 8'h01);
        wr(ADDR_IND1, 8'h55);
        chk("lcdData", 16'h6155, {extAddr, extData});
        chk("lcdWr", 16'h0003, {14'h0000, extWr, extLcd});
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            callAddr <= 12'h200 + 12'(i);
            progCnt <= 12'h100 + 12'(i);
            op(OP_CALL, 8'h00, 8'h00, 1'b0);
            chk("call", 16'h1200 + 16'(i), {3'b000, pcLoad, pcTarget});
            chk("full", {15'h0000, i > 4}, {15'h0000, stackFull});
        end
        @(posedge clk);
        tbIrqReq <= 1'b1;
        progCnt <= 12'h0AA;
        repeat (3) begin
            @(posedge clk);
            #1;
            chk("heldAck", 16'h0000, {15'h0000, tbAck});
        end
        ex(12'h106, VEC_TIMEBASE);
        @(posedge clk);
        tbIrqReq <= 1'b0;
        rtcIrqReq <= 1'b1;
        ex(12'h0AA, VEC_RTC);
        wrap_up;
    end
endmodule
